// File: shared/flash_prog_pkg.sv
package flash_prog_pkg;
  localparam int unsigned FLASH_ADDR_W = 12;
  localparam int unsigned FLASH_BYTES = 4096;
  localparam int unsigned WL_BYTES = 32;
  localparam int unsigned WL_COUNT = 128;
  localparam int unsigned SECTORS = 8;
  localparam int unsigned TIMER_W = 23;
  localparam logic [3:0] MAP_LOW_PAGE = 4'h0;
  localparam logic [3:0] MAP_HIGH_PAGE = 4'hA;
  localparam logic [15:0] WL_STEP = 16'h0020;
  localparam logic [7:0] RAM_PTR_LOC = 8'h18;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [1:0] MAX_PASSES = 2'h2;
  localparam logic [11:0] LOAD_PTR_CNT = 12'h001;
  localparam logic [11:0] LOAD_DATA_CNT = 12'h003;
  localparam logic [11:0] LOAD_LAST_CNT = 12'h022;
  localparam logic [11:0] PROG_LAST_CNT = 12'h01F;
  localparam logic [11:0] ERASE_LAST_CNT = 12'hFFF;
  localparam logic [TIMER_W-1:0] PROG_CYCLES = 23'h33220;
  localparam logic [TIMER_W-1:0] ERASE_CYCLES = 23'h7CBF00;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_LOAD = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_COMMIT = 5'b10000
  } seq_state_t;

  function automatic logic in_flash_window(input logic [15:0] addr);
    return (addr[15:12] == MAP_LOW_PAGE) || (addr[15:12] == MAP_HIGH_PAGE);
  endfunction : in_flash_window
endpackage : flash_prog_pkg

// File: rtl/flash_op_timer.sv
`timescale 1ns/100ps
`default_nettype none
module flash_op_timer
  import flash_prog_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [TIMER_W-1:0] cycles_i,
  input wire logic abort_i,
  output logic done_o
);
  logic [TIMER_W-1:0] remain;
  logic [TIMER_W-1:0] next_remain;
  logic running;
  logic next_running;
  logic next_done;

  always_comb begin
    next_remain = remain;
    next_running = running;
    next_done = 1'b0;
    if (abort_i) begin
      next_running = 1'b0;
    end else if (start_i) begin
      next_remain = cycles_i - 23'h1;
      next_running = 1'b1;
    end else if (running) begin
      if (remain == '0) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_remain = remain - 23'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= '0;
      running <= 1'b0;
      done_o <= 1'b0;
    end else begin
      remain <= next_remain;
      running <= next_running;
      done_o <= next_done;
    end
  end
endmodule : flash_op_timer
`default_nettype wire

// File: rtl/flash_wordline_program_control.sv
`timescale 1ns/100ps
`default_nettype none
module flash_wordline_program_control
  import flash_prog_pkg::*;
#(
  parameter logic [TIMER_W-1:0] PROG_TIME_CYCLES = PROG_CYCLES,
  parameter logic [TIMER_W-1:0] ERASE_TIME_CYCLES = ERASE_CYCLES
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic prog_bg_req_i,
  input wire logic prog_block_req_i,
  input wire logic erase_req_i,
  input wire logic [SECTORS-1:0] erase_sectors_i,
  input wire logic erase_abort_i,
  input wire logic [15:0] target_address_i,
  input wire logic protect_mode1_i,
  input wire logic nmi_event_i,
  input wire logic flash_nmi_enable_i,
  input wire logic flag_clear_i,
  input wire logic [7:0] ram_data_i,
  input wire logic code_rd_i,
  input wire logic [15:0] code_addr_i,
  output logic [7:0] ram_addr_o,
  output logic ram_rd_o,
  output logic [7:0] code_data_o,
  output logic code_valid_o,
  output logic code_refused_o,
  output logic bank_ready_o,
  output logic stall_o,
  output logic result_valid_o,
  output logic result_carry_flag_o,
  output logic [15:0] target_address_pointer_o,
  output logic flash_done_flag_o,
  output logic nmi_o
);
  logic [7:0] flash_mem [FLASH_BYTES];
  logic [7:0] data_buf [WL_BYTES];

  seq_state_t state;
  seq_state_t next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic blocking;
  logic next_blocking;
  logic erasing;
  logic next_erasing;
  logic nmi_seen;
  logic next_nmi_seen;
  logic [SECTORS-1:0] sectors;
  logic [SECTORS-1:0] next_sectors;
  logic [6:0] wordline;
  logic [6:0] next_wordline;
  logic [WL_COUNT-1:0][1:0] passes;
  logic [WL_COUNT-1:0][1:0] next_passes;
  logic [7:0] next_ram_addr;
  logic next_ram_rd;
  logic next_ready;
  logic next_stall;
  logic next_result_valid;
  logic next_carry;
  logic [15:0] next_pointer;
  logic next_flag;
  logic timer_start;
  logic timer_done;
  logic [TIMER_W-1:0] timer_cycles;
  logic commit_prog;
  logic commit_erase;
  logic [FLASH_ADDR_W-1:0] commit_idx;
  logic check_fail;

  flash_op_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(timer_start),
    .cycles_i(timer_cycles),
    .abort_i(erase_abort_i && erasing && (state == ST_WAIT)),
    .done_o(timer_done)
  );

  // Precondition check; a third pass on one wordline is refused.
  assign check_fail = protect_mode1_i || nmi_seen || nmi_event_i ||
                      (erasing ? (sectors == '0) : (passes[wordline] >= MAX_PASSES));
  assign commit_prog = (state == ST_COMMIT) && !erasing;
  assign commit_erase = (state == ST_COMMIT) && erasing;
  assign commit_idx = erasing ? cnt : {wordline, cnt[4:0]};

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_blocking = blocking;
    next_erasing = erasing;
    next_nmi_seen = nmi_seen;
    next_sectors = sectors;
    next_wordline = wordline;
    next_passes = passes;
    next_ram_addr = ram_addr_o;
    next_ram_rd = 1'b0;
    next_stall = stall_o;
    next_result_valid = 1'b0;
    next_carry = result_carry_flag_o;
    next_pointer = target_address_pointer_o;
    next_flag = flash_done_flag_o;
    timer_start = 1'b0;
    timer_cycles = erasing ? ERASE_TIME_CYCLES : PROG_TIME_CYCLES;
    if (flag_clear_i) begin
      next_flag = 1'b0;
    end
    if (blocking && nmi_event_i) begin
      next_nmi_seen = 1'b1;
    end
    case (state)
      ST_IDLE: begin
        next_cnt = '0;
        next_nmi_seen = 1'b0;
        if (prog_bg_req_i || prog_block_req_i) begin
          next_state = ST_CHECK;
          next_blocking = prog_block_req_i && !prog_bg_req_i;
          next_stall = prog_block_req_i && !prog_bg_req_i;
          next_erasing = 1'b0;
          next_wordline = target_address_i[11:5];
          next_pointer = target_address_i;
        end else if (erase_req_i) begin
          next_state = ST_CHECK;
          next_blocking = 1'b0;
          next_erasing = 1'b1;
          next_sectors = erase_sectors_i;
        end
      end
      ST_CHECK: begin
        if (check_fail) begin
          next_state = ST_IDLE;
          next_stall = 1'b0;
          next_result_valid = 1'b1;
          next_carry = 1'b1;
        end else if (erasing) begin
          next_state = ST_WAIT;
          timer_start = 1'b1;
          next_result_valid = 1'b1;
          next_carry = 1'b0;
        end else begin
          next_state = ST_LOAD;
          next_ram_addr = RAM_PTR_LOC;
          next_ram_rd = 1'b1;
          if (!blocking) begin
            next_result_valid = 1'b1;
            next_carry = 1'b0;
            next_pointer = target_address_pointer_o + WL_STEP;
          end
        end
      end
      ST_LOAD: begin
        next_cnt = cnt + 12'h001;
        next_ram_rd = (cnt < LOAD_LAST_CNT);
        if (cnt == LOAD_PTR_CNT) begin
          next_ram_addr = ram_data_i;
        end else if (cnt > LOAD_PTR_CNT) begin
          next_ram_addr = ram_addr_o + 8'h01;
        end
        if (cnt == LOAD_LAST_CNT) begin
          next_state = ST_WAIT;
          next_ram_rd = 1'b0;
          timer_start = 1'b1;
        end
      end
      ST_WAIT: begin
        next_cnt = '0;
        if (erasing && erase_abort_i) begin
          next_state = ST_IDLE;
        end else if (timer_done) begin
          next_state = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        next_cnt = cnt + 12'h001;
        if (erasing && (cnt == ERASE_LAST_CNT)) begin
          next_state = ST_IDLE;
          next_flag = 1'b1;
          for (int w = 0; w < WL_COUNT; w++) begin
            if (sectors[w / (WL_COUNT / SECTORS)]) begin
              next_passes[w] = 2'h0;
            end
          end
        end else if (!erasing && (cnt == PROG_LAST_CNT)) begin
          next_state = ST_IDLE;
          next_passes[wordline] = passes[wordline] + 2'h1;
          if (blocking) begin
            next_stall = 1'b0;
            next_result_valid = 1'b1;
            next_carry = nmi_seen || nmi_event_i;
            next_flag = 1'b0;
            if (!(nmi_seen || nmi_event_i)) begin
              next_pointer = target_address_pointer_o + WL_STEP;
            end
          end else begin
            next_flag = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_ready = (next_state == ST_IDLE);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      cnt <= '0;
      blocking <= 1'b0;
      erasing <= 1'b0;
      nmi_seen <= 1'b0;
      sectors <= '0;
      wordline <= '0;
      passes <= '0;
      ram_addr_o <= '0;
      ram_rd_o <= 1'b0;
      bank_ready_o <= 1'b1;
      stall_o <= 1'b0;
      result_valid_o <= 1'b0;
      result_carry_flag_o <= 1'b0;
      target_address_pointer_o <= '0;
      flash_done_flag_o <= 1'b0;
      nmi_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      blocking <= next_blocking;
      erasing <= next_erasing;
      nmi_seen <= next_nmi_seen;
      sectors <= next_sectors;
      wordline <= next_wordline;
      passes <= next_passes;
      ram_addr_o <= next_ram_addr;
      ram_rd_o <= next_ram_rd;
      bank_ready_o <= next_ready;
      stall_o <= next_stall;
      result_valid_o <= next_result_valid;
      result_carry_flag_o <= next_carry;
      target_address_pointer_o <= next_pointer;
      flash_done_flag_o <= next_flag;
      nmi_o <= next_flag && flash_nmi_enable_i;
    end
  end

  // Array, staging buffer and read port; the array has no reset as it is nonvolatile.
  always_ff @(posedge sys_clk_i) begin
    if ((state == ST_LOAD) && (cnt >= LOAD_DATA_CNT)) begin
      data_buf[5'(cnt - LOAD_DATA_CNT)] <= ram_data_i;
    end
    if (commit_prog) begin
      flash_mem[commit_idx] <= flash_mem[commit_idx] | data_buf[cnt[4:0]];
    end
    if (commit_erase && sectors[commit_idx[11:9]]) begin
      flash_mem[commit_idx] <= ERASED_BYTE;
    end
    if (code_rd_i) begin
      code_data_o <= flash_mem[code_addr_i[FLASH_ADDR_W-1:0]];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_valid_o <= 1'b0;
      code_refused_o <= 1'b0;
    end else begin
      code_valid_o <= code_rd_i && bank_ready_o && in_flash_window(code_addr_i);
      code_refused_o <= code_rd_i && !(bank_ready_o && in_flash_window(code_addr_i));
    end
  end
endmodule : flash_wordline_program_control
`default_nettype wire

// File: tb/flash_wpc_props.sv
`timescale 1ns/100ps
`default_nettype none
module flash_wpc_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic prog_bg_req_i,
  input wire logic flash_nmi_enable_i,
  input wire logic code_rd_i,
  input wire logic [15:0] code_addr_i,
  input wire logic code_refused_o,
  input wire logic bank_ready_o,
  input wire logic stall_o,
  input wire logic result_valid_o,
  input wire logic result_carry_flag_o,
  input wire logic [15:0] target_address_pointer_o,
  input wire logic flash_done_flag_o,
  input wire logic nmi_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_stall; stall_o |-> !bank_ready_o; endproperty
  a_stall: assert property (p_stall) else $error("stall while ready");
  property p_nmi; nmi_o == (flash_done_flag_o && $past(flash_nmi_enable_i)); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi mismatch");
  property p_bg; bank_ready_o && prog_bg_req_i |-> ##[1:3] result_valid_o; endproperty
  a_bg: assert property (p_bg) else $error("no early result");
  property p_pulse; result_valid_o |=> !result_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("result too long");
  property p_keep; result_valid_o && result_carry_flag_o |-> $stable(target_address_pointer_o);
  endproperty
  a_keep: assert property (p_keep) else $error("pointer moved");
  property p_busy; code_rd_i && !bank_ready_o |=> code_refused_o; endproperty
  a_busy: assert property (p_busy) else $error("busy read taken");
  property p_map; code_rd_i && !(code_addr_i[15:12] inside {4'h0, 4'hA}) |=> code_refused_o;
  endproperty
  a_map: assert property (p_map) else $error("bad range taken");
  property p_end; $fell(stall_o) |-> ##[0:1] (result_valid_o && !flash_done_flag_o); endproperty
  a_end: assert property (p_end) else $error("blocking end wrong");
  c_ok: cover property (result_valid_o && !result_carry_flag_o);
  c_fail: cover property (result_valid_o && result_carry_flag_o);
  c_nmi: cover property ($rose(nmi_o));
endmodule : flash_wpc_props
bind flash_wordline_program_control flash_wpc_props u_props (.sys_clk_i, .rst_n_i,
  .prog_bg_req_i, .flash_nmi_enable_i, .code_rd_i, .code_addr_i, .code_refused_o,
  .bank_ready_o, .stall_o, .result_valid_o, .result_carry_flag_o,
  .target_address_pointer_o, .flash_done_flag_o, .nmi_o);
`default_nettype wire

// File: tb/ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module ram_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] ram_addr_i,
  input wire logic ram_rd_i,
  input wire logic [7:0] seed_i,
  input wire logic zero_lo_i,
  output logic [7:0] ram_data_o
);
  logic [7:0] level = 8'h5A;
  // Outside a read the data lines toggle so stale bytes never look valid.
  always @(posedge sys_clk_i) begin
    if (!ram_rd_i) begin
      level <= ~level;
    end else if (ram_addr_i == 8'h18) begin
      level <= 8'h40;
    end else begin
      level <= (zero_lo_i && !ram_addr_i[4]) ? 8'h00 : ram_addr_i ^ seed_i;
    end
  end
  assign ram_data_o = level;
endmodule : ram_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import flash_prog_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic bg = 1'b0, blk = 1'b0, ers = 1'b0, abrt = 1'b0, prot = 1'b0, nev = 1'b0;
  logic nen = 1'b0, fclr = 1'b0, crd = 1'b0, zlo = 1'b0, ram_rd, cvalid, cref;
  logic ready, stall, rvalid, carry, flag, nmi;
  logic [7:0] sec = 8'h00, seed = 8'h01, ram_addr, ram_data, cdata;
  logic [15:0] tgt = 16'h0040, caddr = 16'h0000, ptr;
  int err_count = 0, n_compared = 0;

  flash_wordline_program_control #(.PROG_TIME_CYCLES(23'h14), .ERASE_TIME_CYCLES(23'h28)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .prog_bg_req_i(bg), .prog_block_req_i(blk),
    .erase_req_i(ers), .erase_sectors_i(sec), .erase_abort_i(abrt), .target_address_i(tgt),
    .protect_mode1_i(prot), .nmi_event_i(nev), .flash_nmi_enable_i(nen), .flag_clear_i(fclr),
    .ram_data_i(ram_data), .code_rd_i(crd), .code_addr_i(caddr), .ram_addr_o(ram_addr),
    .ram_rd_o(ram_rd), .code_data_o(cdata), .code_valid_o(cvalid), .code_refused_o(cref),
    .bank_ready_o(ready), .stall_o(stall), .result_valid_o(rvalid),
    .result_carry_flag_o(carry), .target_address_pointer_o(ptr),
    .flash_done_flag_o(flag), .nmi_o(nmi));
  ram_model ram (.sys_clk_i(sys_clk_i), .ram_addr_i(ram_addr), .ram_rd_i(ram_rd),
    .seed_i(seed), .zero_lo_i(zlo), .ram_data_o(ram_data));

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic conclude();
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Kind 0 is background program, 1 blocking program, 2 erase.
  task automatic request(input int kind, input int lim);
    @(posedge sys_clk_i);
    bg <= (kind == 0);
    blk <= (kind == 1);
    ers <= (kind == 2);
    @(posedge sys_clk_i);
    bg <= 1'b0;
    blk <= 1'b0;
    ers <= 1'b0;
    repeat (lim) begin
      @(posedge sys_clk_i);
      if (rvalid === 1'b1) return;
    end
    check(1'b0, 1'b1, "no result");
  endtask : request

  task automatic wait_ready(input logic need_flag, input int lim);
    repeat (lim) begin
      @(posedge sys_clk_i);
      if (ready === 1'b1 && (flag === 1'b1 || !need_flag)) return;
    end
    check(1'b0, 1'b1, "not ready");
  endtask : wait_ready

  task automatic rd(input logic [15:0] a, input logic ok, input logic [7:0] exp);
    @(posedge sys_clk_i);
    crd <= 1'b1;
    caddr <= a;
    @(posedge sys_clk_i);
    crd <= 1'b0;
    @(posedge sys_clk_i);
    check({cvalid, cref}, ok ? 2'b10 : 2'b01, "read status");
    if (ok) check(cdata, exp, "read data");
  endtask : rd

  function automatic logic [7:0] pat(input int k, input logic [7:0] s);
    return 8'(8'h40 + k) ^ s;
  endfunction : pat

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    check(ready, 1'b1, "ready");
    sec <= 8'hFF;
    request(2, 10);
    check(carry, 1'b0, "erase start");
    wait_ready(1'b1, 6000);
    rd(16'hA05F, 1'b1, 8'h00);
    fclr <= 1'b1;
    nen <= 1'b1;
    @(posedge sys_clk_i);
    fclr <= 1'b0;
    request(0, 10);
    check(carry, 1'b0, "bg carry");
    check(nmi, 1'b0, "nmi early");
    check(ptr, 16'h0040 + WL_STEP, "bg ptr");
    rd(16'h0040, 1'b0, 8'h00);
    wait_ready(1'b1, 500);
    @(posedge sys_clk_i);
    check(nmi, 1'b1, "nmi");
    for (int k = 0; k < 32; k++) begin
      rd(16'(k) + ((k % 2) ? 16'hA040 : 16'h0040), 1'b1, pat(k, 8'h01));
    end
    rd(16'h0060, 1'b1, 8'h00);
    rd(16'h1040, 1'b0, 8'h00);
    fclr <= 1'b1;
    nen <= 1'b0;
    seed <= 8'h80;
    zlo <= 1'b1;
    @(posedge sys_clk_i);
    fclr <= 1'b0;
    request(1, 2000);
    check({carry, flag}, 2'b00, "block end");
    for (int k = 0; k < 32; k++) begin
      rd(16'h0040 + 16'(k), 1'b1,
         (k < 16) ? pat(k, 8'h01) : pat(k, 8'h01) | pat(k, 8'h80));
    end
    request(1, 2000);
    check({carry, ptr}, {1'b1, 16'h0040}, "third pass");
    tgt <= 16'h0080;
    prot <= 1'b1;
    request(1, 2000);
    check({carry, ptr}, {1'b1, 16'h0080}, "protected");
    prot <= 1'b0;
    fork
      request(1, 2000);
      begin
        repeat (12) @(posedge sys_clk_i);
        nev <= 1'b1;
        @(posedge sys_clk_i);
        nev <= 1'b0;
      end
    join
    check({carry, ptr}, {1'b1, 16'h0080}, "nmi during block");
    sec <= 8'h00;
    request(2, 10);
    check(carry, 1'b1, "no sector");
    sec <= 8'h01;
    request(2, 10);
    repeat (5) @(posedge sys_clk_i);
    abrt <= 1'b1;
    wait_ready(1'b0, 100);
    abrt <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    check(flag, 1'b0, "abort flag");
    rd(16'h0050, 1'b1, pat(16, 8'h01) | pat(16, 8'h80));
    conclude();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    conclude();
  end
endmodule : tb
`default_nettype wire
